// ### ebct_pkg.sv
package ebct_pkg;

  // data width and expanded group that holds the timer registers
  localparam int         DATA_W    = 8;
  localparam logic [3:0] GROUP_D   = 4'hD;

  // register offsets inside the group
  localparam logic [3:0] CTL_OFS   = 4'h0;
  localparam logic [3:0] MODE_OFS  = 4'h1;
  localparam logic [3:0] LOW_OFS   = 4'h4;
  localparam logic [3:0] UP_OFS    = 4'h5;
  localparam logic [3:0] WLOW_OFS  = 4'h6;

  // timer8_control field positions
  localparam int RUN_BIT    = 7;
  localparam int SINGLE_BIT = 6;
  localparam int TOUT_BIT   = 5;
  localparam int CLK_HI_BIT = 4;
  localparam int CLK_LO_BIT = 3;
  localparam int CAPMSK_BIT = 2;
  localparam int TOIE_BIT   = 1;
  localparam int OUTSEL_BIT = 0;

  // timer_mode_control field positions
  localparam int DEMOD_BIT   = 6;
  localparam int EDGE_HI_BIT = 1;
  localparam int EDGE_LO_BIT = 0;

  // values after reset and special counts
  localparam logic [6:0] CFG_RST   = 7'h00;
  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] HOLD_RST  = 8'h00;
  localparam logic [7:0] ALL_ONES  = 8'hFF;
  localparam logic [7:0] CNT_ONE   = 8'h01;
  localparam logic [7:0] CNT_ZERO  = 8'h00;
  localparam logic [2:0] DIV_RST   = 3'h0;
  // fields kept across a stop-mode recovery: flag, clock, masks
  localparam logic [6:0] SMR_KEEP  = 7'h3E;

  // counter run state
  typedef enum logic [1:0] {
    ST_STOP = 2'b01,
    ST_RUN  = 2'b10
  } ebct_state_t;

endpackage : ebct_pkg

// ### ebct_tick_div.sv
`timescale 1ns/1ps
module ebct_tick_div
  import ebct_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       run_in,
  input  wire logic [1:0] sel_in,
  output logic            tick_out
);

  logic [2:0] div_r;
  logic [2:0] mask_w;

  // mask of low divider bits that must be all ones for a tick
  assign mask_w = (sel_in == 2'b00) ? 3'h0 :
                  (sel_in == 2'b01) ? 3'h1 :
                  (sel_in == 2'b10) ? 3'h3 : 3'h7;

  // one-cycle enable at the selected fraction of the system tick
  assign tick_out = run_in && ((div_r & mask_w) == mask_w);

  // free running divider, held at zero while the counter is stopped
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      div_r <= DIV_RST;
    else if (!run_in)
      div_r <= DIV_RST;
    else
      div_r <= div_r + 3'h1;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // ticks of a divided rate are spaced by the full divide count
  div_four_a: assert property (tick_out && sel_in == 2'b10
                               |=> (!tick_out || sel_in != 2'b10) [*3])
    else $error("divide by four tick too early");
  div_eight_a: assert property (tick_out && sel_in == 2'b11
                                |=> (!tick_out || sel_in != 2'b11) [*7])
    else $error("divide by eight tick too early");

endmodule : ebct_tick_div

// ### ebct_timer.sv
`timescale 1ns/1ps
module ebct_timer
  import ebct_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       smr_in,
  input  wire logic [3:0] grp_in,
  input  wire logic [3:0] addr_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out,
  input  wire logic       cap_pin_in,
  output logic      [7:0] count_out,
  output logic            running_out,
  output logic            capture_irq_out,
  output logic            timeout_irq_out
);

  ebct_state_t state_r;
  ebct_state_t state_nxt;
  logic [6:0]  cfg_r;
  logic [6:0]  cfg_nxt;
  logic [7:0]  mode_r;
  logic [7:0]  mode_nxt;
  logic [7:0]  low_r;
  logic [7:0]  up_r;
  logic [7:0]  wlow_r;
  logic [7:0]  cnt_r;
  logic [7:0]  cnt_nxt;
  logic [7:0]  rdata_nxt;
  logic [7:0]  rdata_r;
  logic        sync1_r;
  logic        sync2_r;
  logic        prev_r;
  logic        cap_irq_r;
  logic        to_irq_r;

  // register select within the expanded group
  function automatic logic hit_fn(input logic [3:0] grp,
                                  input logic [3:0] addr,
                                  input logic [3:0] ofs);
    return (grp == GROUP_D) && (addr == ofs);
  endfunction : hit_fn

  // write strobes for each register
  wire wr_ctl_w  = wr_in && hit_fn(grp_in, addr_in, CTL_OFS);
  wire wr_mode_w = wr_in && hit_fn(grp_in, addr_in, MODE_OFS);
  wire wr_low_w  = wr_in && hit_fn(grp_in, addr_in, LOW_OFS);
  wire wr_up_w   = wr_in && hit_fn(grp_in, addr_in, UP_OFS);
  wire wr_wlow_w = wr_in && hit_fn(grp_in, addr_in, WLOW_OFS);

  // divided counting tick
  wire run_w  = (state_r == ST_RUN);
  wire tick_w;

  ebct_tick_div u_div (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .run_in   (run_w),
    .sel_in   (cfg_r[CLK_HI_BIT:CLK_LO_BIT]),
    .tick_out (tick_w)
  );

  // capture pin synchroniser; prev_r keeps the last settled level
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end
    else
    begin
      sync1_r <= cap_pin_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // events of the counter
  wire demod_w  = mode_r[DEMOD_BIT];
  wire single_w = cfg_r[SINGLE_BIT];
  wire rise_w   = sync2_r && !prev_r;
  wire fall_w   = !sync2_r && prev_r;
  wire cap_w    = run_w && demod_w && (rise_w || fall_w);
  wire reach_w  = run_w && tick_w && (cnt_r <= CNT_ONE) && !cap_w;
  wire start_w  = wr_ctl_w && wdata_in[RUN_BIT] && !run_w;
  wire stop_w   = (wr_ctl_w && !wdata_in[RUN_BIT]) || smr_in;
  wire sp_end_w = reach_w && !demod_w && single_w;

  // run state machine
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_STOP:
        if (start_w && !smr_in)
          state_nxt = ST_RUN;
      ST_RUN:
        if (stop_w || sp_end_w)
          state_nxt = ST_STOP;
      default:
        state_nxt = ST_STOP;
    endcase
  end

  // counter: start load, capture reload, zero handling, decrement
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (start_w)
      cnt_nxt = demod_w ? ALL_ONES : low_r;
    else if (cap_w)
      cnt_nxt = ALL_ONES;
    else if (reach_w && demod_w)
      cnt_nxt = ALL_ONES;
    else if (reach_w)
      cnt_nxt = single_w ? CNT_ZERO : low_r;
    else if (run_w && tick_w)
      cnt_nxt = cnt_r - CNT_ONE;
  end

  // control fields; the time-out set wins over a clear in the same cycle
  always_comb
  begin
    cfg_nxt = cfg_r;
    if (smr_in)
      cfg_nxt = cfg_r & SMR_KEEP;
    if (wr_ctl_w)
    begin
      cfg_nxt[SINGLE_BIT]            = wdata_in[SINGLE_BIT];
      cfg_nxt[CLK_HI_BIT:CLK_LO_BIT] =
        wdata_in[CLK_HI_BIT:CLK_LO_BIT];
      cfg_nxt[CAPMSK_BIT]            = wdata_in[CAPMSK_BIT];
      cfg_nxt[TOIE_BIT]              = wdata_in[TOIE_BIT];
      cfg_nxt[OUTSEL_BIT]            = wdata_in[OUTSEL_BIT];
      if (wdata_in[TOUT_BIT])
        cfg_nxt[TOUT_BIT] = 1'b0;
    end
    if (reach_w)
      cfg_nxt[TOUT_BIT] = 1'b1;
  end

  // mode register; edge status bits clear on write 1, set wins
  always_comb
  begin
    mode_nxt = mode_r;
    if (wr_mode_w)
    begin
      mode_nxt[7:2] = wdata_in[7:2];
      mode_nxt[1:0] = mode_r[1:0] & ~wdata_in[1:0];
    end
    if (cap_w && fall_w)
      mode_nxt[EDGE_HI_BIT] = 1'b1;
    if (cap_w && rise_w)
      mode_nxt[EDGE_LO_BIT] = 1'b1;
  end

  // read data for the addressed register, zero when unmapped
  always_comb
  begin
    if (hit_fn(grp_in, addr_in, CTL_OFS))
      rdata_nxt = {run_w, cfg_r};
    else if (hit_fn(grp_in, addr_in, MODE_OFS))
      rdata_nxt = mode_r;
    else if (hit_fn(grp_in, addr_in, LOW_OFS))
      rdata_nxt = low_r;
    else if (hit_fn(grp_in, addr_in, UP_OFS))
      rdata_nxt = up_r;
    else if (hit_fn(grp_in, addr_in, WLOW_OFS))
      rdata_nxt = wlow_r;
    else
      rdata_nxt = 8'h00;
  end

  // state, counter and control registers
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_r <= ST_STOP;
      cnt_r   <= CNT_ZERO;
      cfg_r   <= CFG_RST;
      mode_r  <= MODE_RST;
      rdata_r <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      cfg_r   <= cfg_nxt;
      mode_r  <= mode_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // hold registers; a capture overrides a software write
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      low_r  <= HOLD_RST;
      up_r   <= HOLD_RST;
      wlow_r <= HOLD_RST;
    end
    else
    begin
      if (cap_w && rise_w)
        low_r <= cnt_r;
      else if (wr_low_w)
        low_r <= wdata_in;
      if (cap_w && fall_w)
        up_r <= cnt_r;
      else if (wr_up_w)
        up_r <= wdata_in;
      if (wr_wlow_w)
        wlow_r <= wdata_in;
    end
  end

  // one-cycle interrupt pulses gated by their enables
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cap_irq_r <= 1'b0;
      to_irq_r  <= 1'b0;
    end
    else
    begin
      cap_irq_r <= cap_w && cfg_r[CAPMSK_BIT];
      to_irq_r  <= reach_w && cfg_r[TOIE_BIT];
    end
  end

  // outputs
  assign rdata_out       = rdata_r;
  assign count_out       = cnt_r;
  assign running_out     = run_w;
  assign capture_irq_out = cap_irq_r;
  assign timeout_irq_out = to_irq_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  run_start_a: assert property (start_w && !smr_in |=> running_out)
    else $error("counter did not start");
  run_stop_a: assert property (run_w && wr_ctl_w && !wdata_in[RUN_BIT]
                               |=> !running_out ##1 !running_out)
    else $error("counter did not stop");
  single_end_a: assert property (sp_end_w && !start_w |=> !running_out
                                 && cnt_r == CNT_ZERO)
    else $error("single pass did not stop at zero");
  flag_clear_a: assert property (wr_ctl_w && wdata_in[TOUT_BIT] && !reach_w
                                 |=> !cfg_r[TOUT_BIT])
    else $error("time-out flag not cleared");
  flag_keep_a: assert property (cfg_r[TOUT_BIT] && !(wr_ctl_w
                                && wdata_in[TOUT_BIT]) |=> cfg_r[TOUT_BIT])
    else $error("time-out flag lost");
  cap_irq_a: assert property (cap_w |=> capture_irq_out
                              == $past(cfg_r[CAPMSK_BIT]))
    else $error("capture interrupt mismatch");
  fall_high_a: assert property (cap_w && fall_w |=> up_r == $past(cnt_r)
                                && mode_r[EDGE_HI_BIT])
    else $error("falling edge capture wrong");
  rise_low_a: assert property (cap_w && rise_w |=> low_r == $past(cnt_r)
                               && mode_r[EDGE_LO_BIT])
    else $error("rising edge capture wrong");
  cap_reload_a: assert property (cap_w && !start_w |=> cnt_r == ALL_ONES)
    else $error("capture did not reload counter");
  demod_wrap_a: assert property (reach_w && demod_w && !start_w
                                 |=> cnt_r == ALL_ONES && cfg_r[TOUT_BIT]
                                 && timeout_irq_out == $past(cfg_r[TOIE_BIT]))
    else $error("demodulation wrap wrong");
  group_gate_a: assert property (wr_in && grp_in != GROUP_D && !cap_w
                                 |=> $stable(low_r) && $stable(up_r))
    else $error("write outside group changed a register");
  smr_keep_a: assert property (smr_in && !wr_ctl_w && !reach_w |=> cfg_r[5:1]
                               == $past(cfg_r[5:1]) && !running_out)
    else $error("stop-mode recovery disturbed kept fields");
  count_dec_a: assert property (run_w && tick_w && cnt_r > CNT_ONE
                                && !cap_w && !wr_ctl_w && !smr_in
                                |=> cnt_r == $past(cnt_r) - CNT_ONE)
    else $error("counter did not decrement");

  capture_c: cover property (cap_w ##1 capture_irq_out);
  wrap_c: cover property (reach_w && demod_w);
  single_c: cover property (sp_end_w ##1 !running_out);
  modulo_c: cover property (reach_w && !single_w && !demod_w);

endmodule : ebct_timer

// ### ebct_cap_src.sv
`timescale 1ns/1ps
// capture source: follows the requested level after a skew
module ebct_cap_src
  import ebct_pkg::*;
#(
  parameter int SKEW_NS = 13
)
(
  input  wire logic level_in,
  output logic      pin_out
);
  // requester holds each level for many counting ticks
  initial pin_out = 1'b0;
  always @(level_in) pin_out <= #(SKEW_NS) level_in;
endmodule : ebct_cap_src

// ### ebct_timer_tb.sv
`timescale 1ns/1ps
module ebct_timer_tb
  import ebct_pkg::*;
;
  typedef struct packed {
    logic [3:0] g;
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } ebct_row_t;

  logic       clk_in, nrst_in, smr_in, wr_in, lvl, cap_pin_in;
  logic       running_out, capture_irq_out, timeout_irq_out;
  logic [3:0] grp_in, addr_in;
  logic [7:0] wdata_in, rdata_out, count_out, pv;
  int         n_errors, cmp_count, i, k, n;
  // write, then read back at the same offset in group D
  ebct_row_t  rows [9] = '{
    '{GROUP_D, LOW_OFS, 8'h5A, 8'h5A}, '{GROUP_D, UP_OFS, 8'hA5, 8'hA5},
    '{GROUP_D, WLOW_OFS, 8'h3C, 8'h3C}, '{4'hC, LOW_OFS, 8'h11, 8'h5A},
    '{GROUP_D, 4'h2, 8'h77, 8'h00}, '{GROUP_D, CTL_OFS, 8'h5E, 8'h5E},
    '{GROUP_D, CTL_OFS, 8'h20, 8'h00}, '{GROUP_D, MODE_OFS, 8'hFF, 8'hFC},
    '{GROUP_D, MODE_OFS, 8'h00, 8'h00}};

  ebct_timer dut (.clk_in(clk_in), .nrst_in(nrst_in), .smr_in(smr_in),
    .grp_in(grp_in), .addr_in(addr_in), .wr_in(wr_in),
    .wdata_in(wdata_in), .rdata_out(rdata_out), .cap_pin_in(cap_pin_in),
    .count_out(count_out), .running_out(running_out),
    .capture_irq_out(capture_irq_out), .timeout_irq_out(timeout_irq_out));
  ebct_cap_src src (.level_in(lvl), .pin_out(cap_pin_in));

  // 25 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      n_errors++;
    end
  endtask : chk

  task automatic report_and_stop();
    if (n_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic cyc(input int c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] g, input logic [3:0] a,
                    input logic [7:0] d);
    @(posedge clk_in);
    grp_in   <= g;
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
    grp_in   <= GROUP_D;
    #1;
  endtask : wr

  // read data follows one edge after the address is taken
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    cyc(1);
    chk(rdata_out, e);
  endtask : rdchk

  // move the pin; with mask set expect irq, FF reload, latched count
  task automatic cap(input logic l, input logic m, input logic [3:0] ofs,
                     input logic [7:0] st);
    logic [7:0] pc;
    @(posedge clk_in);
    lvl <= l;
    for (i = 0; i < 20 && capture_irq_out !== 1'b1; i++)
    begin
      pc = count_out;
      cyc(1);
    end
    if (m)
    begin
      chk(count_out, ALL_ONES);
      rdchk(ofs, pc);
    end
    else
      chk(8'(i), 8'd20);
    rdchk(MODE_OFS, st);
  endtask : cap

  initial
  begin
    nrst_in   = 1'b0;
    smr_in    = 1'b0;
    wr_in     = 1'b0;
    grp_in    = GROUP_D;
    addr_in   = CTL_OFS;
    wdata_in  = 8'h00;
    lvl       = 1'b0;
    n_errors  = 0;
    cmp_count = 0;
    cyc(5);
    chk({running_out, capture_irq_out, timeout_irq_out}, 8'h00);
    chk(count_out, CNT_ZERO);
    @(posedge clk_in) nrst_in <= 1'b1;
    rdchk(CTL_OFS, 8'h00);
    foreach (rows[j])
    begin
      wr(rows[j].g, rows[j].a, rows[j].d);
      rdchk(rows[j].a, rows[j].e);
    end
    // divider: cycles between count steps
    wr(GROUP_D, LOW_OFS, 8'hF0);
    for (k = 0; k < 4; k++)
    begin
      wr(GROUP_D, CTL_OFS, 8'h00);
      wr(GROUP_D, CTL_OFS, 8'h80 | 8'(k << 3));
      cyc(12);
      chk(running_out, 8'h01);
      pv = count_out;
      for (i = 0; i < 20 && count_out === pv; i++) cyc(1);
      pv = count_out;
      for (i = 0; i < 20 && count_out === pv; i++) cyc(1);
      chk(8'(i), 8'(1 << k));
      chk(count_out, pv - 8'h01);
    end
    wr(GROUP_D, CTL_OFS, 8'h00);
    pv = count_out;
    cyc(4);
    chk(count_out, pv);
    chk(running_out, 8'h00);
    // single pass with time-out interrupt
    wr(GROUP_D, LOW_OFS, 8'h03);
    wr(GROUP_D, CTL_OFS, 8'hC2);
    n = 0;
    for (i = 0; i < 40; i++)
    begin
      cyc(1);
      n += (timeout_irq_out === 1'b1) ? 1 : 0;
    end
    chk(8'(n), 8'h01);
    chk(count_out, CNT_ZERO);
    rdchk(CTL_OFS, 8'h62);
    wr(GROUP_D, CTL_OFS, 8'h42);
    rdchk(CTL_OFS, 8'h62);
    wr(GROUP_D, CTL_OFS, 8'h62);
    rdchk(CTL_OFS, 8'h42);
    // repeating mode keeps running past zero
    wr(GROUP_D, LOW_OFS, 8'h02);
    wr(GROUP_D, CTL_OFS, 8'h80);
    cyc(20);
    rdchk(CTL_OFS, 8'hA0);
    // demodulation captures
    wr(GROUP_D, CTL_OFS, 8'h20);
    wr(GROUP_D, MODE_OFS, 8'h40);
    wr(GROUP_D, CTL_OFS, 8'h86);
    cap(1'b1, 1'b1, LOW_OFS, 8'h41);
    cap(1'b0, 1'b1, UP_OFS, 8'h43);
    wr(GROUP_D, MODE_OFS, 8'h43);
    rdchk(MODE_OFS, 8'h40);
    wr(GROUP_D, CTL_OFS, 8'h82);
    cap(1'b1, 1'b0, LOW_OFS, 8'h41);
    // demodulation time-out wraps to FF
    for (i = 0; i < 600 && timeout_irq_out !== 1'b1; i++) cyc(1);
    if (i == 600)
    begin
      n_errors++;
      report_and_stop();
    end
    chk(count_out >= 8'hFE, 8'h01);
    rdchk(CTL_OFS, 8'hA2);
    // stop-mode recovery keeps flag, clock and masks
    wr(GROUP_D, MODE_OFS, 8'h00);
    wr(GROUP_D, LOW_OFS, 8'hF0);
    wr(GROUP_D, CTL_OFS, 8'hDF);
    @(posedge clk_in) smr_in <= 1'b1;
    @(posedge clk_in) smr_in <= 1'b0;
    rdchk(CTL_OFS, 8'h3E);
    chk(running_out, 8'h00);
    // second reset clears everything
    nrst_in <= 1'b0;
    cyc(2);
    nrst_in <= 1'b1;
    rdchk(CTL_OFS, 8'h00);
    report_and_stop();
  end
endmodule : ebct_timer_tb
